// [include/sbfc_pkg.sv]
package sbfc_pkg;
	localparam int PTR_W = 13;
	localparam int DATA_W = 16;
	localparam int SYNC_DEPTH = 3;

	// command address codes
	localparam logic [2:0] CMD_FLOW_CTRL = 3'h4;
	localparam logic [2:0] CMD_FLAG_STAT = 3'h5;
	localparam logic [2:0] CMD_RSVD_A = 3'h6;
	localparam logic [2:0] CMD_RSVD_B = 3'h7;

	// flow control field positions
	localparam int FC_MODE1_LSB = 0;
	localparam int FC_MODE2_LSB = 2;
	localparam int FC_HALT_BIT = 4;
	localparam int FC_USED_W = 5;
	// flag status positions
	localparam int FS_FIRST_BIT = 0;
	localparam int FS_SECOND_BIT = 1;

	typedef enum logic [1:0] {
		SBFC_CHAIN = 2'b00,
		SBFC_STOP = 2'b01,
		SBFC_LINEAR = 2'b10,
		SBFC_MASK = 2'b11
	} sbfc_mode_e;

	localparam sbfc_mode_e MODE_RST = SBFC_CHAIN;
	localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
	localparam logic [DATA_W-1:0] BUS_ALL_HIGH = 16'hffff;

	// sequential-side controls, all active low
	typedef struct packed {
		logic count_advance_enable_n;
		logic pointer_load_n;
		logic jump_first_start_n;
		logic jump_second_start_n;
	} sbfc_seq_ctl_s;

	typedef struct packed {
		logic [PTR_W-1:0] start_first;
		logic [PTR_W-1:0] end_first;
		logic [PTR_W-1:0] start_second;
		logic [PTR_W-1:0] end_second;
	} sbfc_bounds_s;

	// random-port command pins
	typedef struct packed {
		logic cmd_sel_n;
		logic chip_sel;
		logic rd_wr_n;
		logic [2:0] addr;
		logic [DATA_W-1:0] wdata;
	} sbfc_cmd_s;
endpackage

// [src/sbfc_core.sv]
`timescale 1ns/1ps
// Overview of operation
// - chaining: flag at end, jump other start
// - stop: flag at end, halt at end+1 or end
// - halted pointer blocks sequential writes
// - linear: flag at end, keep incrementing
// - mask: no flag pin, status set, increment
// - writing bit4 zero releases halt; re-halts unless a count follows next cycle
// - load and start jumps also release halt
// - equal ends assert both flags together
// - equal ends chain to first start
// - status write zero clears, one keeps
// - either or both flags clear per write
// - status read shows reached-end bits
// - reserved reads return all ones
// - flow control upper bits read high, ignored
// - command cycle: select low, chip select high
// - reset: flags high, both buffers chaining
module sbfc_core
	import sbfc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// random-port command pins
	input wire sbfc_pkg::sbfc_cmd_s cmd_pins,
	output logic [sbfc_pkg::DATA_W-1:0] cmd_rdata,
	output logic cmd_rdata_oe,
	// sequential side
	input wire sbfc_pkg::sbfc_seq_ctl_s seq_ctl,
	input wire logic [sbfc_pkg::PTR_W-1:0] load_addr,
	input wire sbfc_pkg::sbfc_bounds_s bounds,
	output logic [sbfc_pkg::PTR_W-1:0] seq_pointer,
	output logic seq_write_block,
	// buffer flags
	output logic end_flag_first_n,
	output logic end_flag_second_n
);
	import sbfc_pkg::*;

	typedef struct packed {
		logic [SYNC_DEPTH-1:0] sel_n_s;
		logic [SYNC_DEPTH-1:0] cs_s;
		logic [SYNC_DEPTH-1:0] rw_s;
		logic [1:0][2:0] addr_s;
		logic [1:0][DATA_W-1:0] wd_s;
		logic sel_n_lvl;
		logic cs_lvl;
		logic rw_lvl;
		logic cmd_prev;
		logic [PTR_W-1:0] ptr;
		logic ld_pend;
		logic [PTR_W-1:0] ld_data;
		sbfc_mode_e mode1;
		sbfc_mode_e mode2;
		logic halted;
		logic rel_pend;
		logic [1:0] status;
		logic flag1_n;
		logic flag2_n;
		logic [DATA_W-1:0] rdata;
		logic rdata_oe;
	} sbfc_state_s;

	sbfc_state_s st_r;
	sbfc_state_s st_nxt;

	// a change on a pin counts once the last two stages agree
	function automatic logic settle(input logic [SYNC_DEPTH-1:0] s, input logic lvl);
		settle = (s[1] == s[2]) ? s[2] : lvl;
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = PTR_W'(p + 1'b1);
	endfunction

	logic cmd_act;
	logic cmd_start;
	logic cmd_wr;
	logic [2:0] cmd_addr;
	logic [DATA_W-1:0] cmd_wd;
	logic cnt_en;
	logic match1;
	logic match2;
	logic release_wr;
	sbfc_mode_e end_mode;

	always_comb begin
		st_nxt = st_r;
		st_nxt.sel_n_s = {st_r.sel_n_s[SYNC_DEPTH-2:0], cmd_pins.cmd_sel_n};
		st_nxt.cs_s = {st_r.cs_s[SYNC_DEPTH-2:0], cmd_pins.chip_sel};
		st_nxt.rw_s = {st_r.rw_s[SYNC_DEPTH-2:0], cmd_pins.rd_wr_n};
		st_nxt.addr_s = {st_r.addr_s[0], cmd_pins.addr};
		st_nxt.wd_s = {st_r.wd_s[0], cmd_pins.wdata};
		st_nxt.sel_n_lvl = settle(st_r.sel_n_s, st_r.sel_n_lvl);
		st_nxt.cs_lvl = settle(st_r.cs_s, st_r.cs_lvl);
		st_nxt.rw_lvl = settle(st_r.rw_s, st_r.rw_lvl);

		// address and data are stable by the time the selects have settled
		cmd_act = !st_r.sel_n_lvl && st_r.cs_lvl;
		cmd_start = cmd_act && !st_r.cmd_prev;
		cmd_wr = cmd_start && !st_r.rw_lvl;
		cmd_addr = st_r.addr_s[1];
		cmd_wd = st_r.wd_s[1];
		st_nxt.cmd_prev = cmd_act;

		release_wr = cmd_wr && (cmd_addr == CMD_FLOW_CTRL) && !cmd_wd[FC_HALT_BIT];
		if (cmd_wr && cmd_addr == CMD_FLOW_CTRL) begin
			// upper bits are dropped on write
			st_nxt.mode1 = sbfc_mode_e'(cmd_wd[FC_MODE1_LSB +: 2]);
			st_nxt.mode2 = sbfc_mode_e'(cmd_wd[FC_MODE2_LSB +: 2]);
		end

		cnt_en = !seq_ctl.count_advance_enable_n;
		match1 = st_r.ptr == bounds.end_first;
		match2 = st_r.ptr == bounds.end_second;
		end_mode = match1 ? st_r.mode1 : st_r.mode2;
		st_nxt.rel_pend = 1'b0;

		// pointer movement
		if (st_r.ld_pend) begin
			st_nxt.ptr = st_r.ld_data;
			st_nxt.ld_pend = 1'b0;
			st_nxt.halted = 1'b0;
		end else if (!seq_ctl.pointer_load_n) begin
			st_nxt.ld_pend = 1'b1;
			st_nxt.ld_data = load_addr;
			st_nxt.halted = 1'b0;
		end else if (!seq_ctl.jump_first_start_n) begin
			st_nxt.ptr = bounds.start_first;
			st_nxt.halted = 1'b0;
		end else if (!seq_ctl.jump_second_start_n) begin
			st_nxt.ptr = bounds.start_second;
			st_nxt.halted = 1'b0;
		end else if (release_wr && st_r.halted) begin
			// release acts off the counting path; position is kept
			// gated by halted so a plain mode write never steals a count
			st_nxt.halted = 1'b0;
			st_nxt.rel_pend = st_r.halted;
		end else if (st_r.rel_pend && !cnt_en) begin
			st_nxt.halted = 1'b1;
		end else if (st_r.halted) begin
			st_nxt.ptr = st_r.ptr;
		end else if ((match1 || match2) && !st_r.rel_pend) begin
			case (end_mode)
				SBFC_CHAIN: begin
					// equal ends: first buffer wins
					if (match1 && match2)
						st_nxt.ptr = bounds.start_first;
					else if (match1)
						st_nxt.ptr = bounds.start_second;
					else
						st_nxt.ptr = bounds.start_first;
				end
				SBFC_STOP: begin
					if (cnt_en)
						st_nxt.ptr = ptr_inc(st_r.ptr);
					st_nxt.halted = 1'b1;
				end
				SBFC_LINEAR: begin
					if (cnt_en)
						st_nxt.ptr = ptr_inc(st_r.ptr);
				end
				SBFC_MASK: begin
					if (cnt_en)
						st_nxt.ptr = ptr_inc(st_r.ptr);
				end
				default: st_nxt.ptr = st_r.ptr;
			endcase
		end else if (cnt_en) begin
			st_nxt.ptr = ptr_inc(st_r.ptr);
		end

		// flag status: clears first, then a same-cycle set wins
		if (cmd_wr && cmd_addr == CMD_FLAG_STAT) begin
			if (!cmd_wd[FS_FIRST_BIT])
				st_nxt.status[FS_FIRST_BIT] = 1'b0;
			if (!cmd_wd[FS_SECOND_BIT])
				st_nxt.status[FS_SECOND_BIT] = 1'b0;
		end
		if (match1)
			st_nxt.status[FS_FIRST_BIT] = 1'b1;
		if (match2)
			st_nxt.status[FS_SECOND_BIT] = 1'b1;
		st_nxt.flag1_n = !(st_nxt.status[FS_FIRST_BIT] && st_nxt.mode1 != SBFC_MASK);
		st_nxt.flag2_n = !(st_nxt.status[FS_SECOND_BIT] && st_nxt.mode2 != SBFC_MASK);

		// read path
		st_nxt.rdata_oe = cmd_act && st_r.rw_lvl;
		st_nxt.rdata = BUS_ALL_HIGH;
		case (cmd_addr)
			CMD_FLOW_CTRL: begin
				st_nxt.rdata[FC_MODE1_LSB +: 2] = st_r.mode1;
				st_nxt.rdata[FC_MODE2_LSB +: 2] = st_r.mode2;
				st_nxt.rdata[FC_HALT_BIT] = st_r.halted;
			end
			CMD_FLAG_STAT: st_nxt.rdata = {{(DATA_W-2){1'b0}}, st_r.status};
			CMD_RSVD_A, CMD_RSVD_B: st_nxt.rdata = BUS_ALL_HIGH;
			// start and end registers live outside this block
			default: st_nxt.rdata = BUS_ALL_HIGH;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.sel_n_s <= '1;
			st_r.sel_n_lvl <= 1'b1;
			st_r.rw_s <= '1;
			st_r.rw_lvl <= 1'b1;
			st_r.ptr <= PTR_RST;
			st_r.mode1 <= MODE_RST;
			st_r.mode2 <= MODE_RST;
			st_r.flag1_n <= 1'b1;
			st_r.flag2_n <= 1'b1;
			st_r.rdata <= BUS_ALL_HIGH;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_rdata = st_r.rdata;
	assign cmd_rdata_oe = st_r.rdata_oe;
	assign seq_pointer = st_r.ptr;
	assign seq_write_block = st_r.halted;
	assign end_flag_first_n = st_r.flag1_n;
	assign end_flag_second_n = st_r.flag2_n;
endmodule // sbfc_core

// [verif/sbfc_core_sva.sv]
`timescale 1ns/1ps
module sbfc_core_sva
	import sbfc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// command port
	input wire sbfc_pkg::sbfc_cmd_s cmd_pins,
	input wire logic [sbfc_pkg::DATA_W-1:0] cmd_rdata,
	input wire logic cmd_rdata_oe,
	// sequential side
	input wire sbfc_pkg::sbfc_seq_ctl_s seq_ctl,
	input wire logic [sbfc_pkg::PTR_W-1:0] load_addr,
	input wire sbfc_pkg::sbfc_bounds_s bounds,
	input wire logic [sbfc_pkg::PTR_W-1:0] seq_pointer,
	input wire logic seq_write_block,
	input wire logic end_flag_first_n,
	input wire logic end_flag_second_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic [2:0] a = cmd_pins.addr;
	// mask mode hides the pin, so only its cause is checked
	chk_flag_cause: assert property ($fell(end_flag_first_n) |->
		$past(seq_pointer) == bounds.end_first || $past(seq_pointer, 2) == bounds.end_first) else $error("flag cause");
	chk_halt_hold: assert property (seq_write_block ##1 seq_write_block |-> $stable(seq_pointer))
		else $error("halted pointer moved");
	chk_load_late: assert property (!seq_ctl.pointer_load_n |->
		##2 seq_pointer == $past(load_addr, 2) && !seq_write_block) else $error("load");
	chk_jump_release: assert property (!seq_ctl.jump_second_start_n |=>
		seq_pointer == bounds.start_second && !seq_write_block) else $error("jump");
	chk_read_cause: assert property ($rose(cmd_rdata_oe) |-> $past(cmd_pins.rd_wr_n, 3) &&
		!$past(cmd_pins.cmd_sel_n, 3) && $past(cmd_pins.chip_sel, 3)) else $error("oe cause");
	chk_rsvd_ones: assert property (cmd_rdata_oe && a != CMD_FLOW_CTRL && a != CMD_FLAG_STAT |->
		cmd_rdata == BUS_ALL_HIGH) else $error("reserved read");
	chk_fc_upper: assert property (cmd_rdata_oe && a == CMD_FLOW_CTRL |-> &cmd_rdata[15:5])
		else $error("fc upper");
	chk_fs_upper: assert property (cmd_rdata_oe && a == CMD_FLAG_STAT |-> cmd_rdata[15:2] == '0)
		else $error("fs upper");
	cover property ($rose(seq_write_block));
	cover property ($fell(end_flag_first_n) && $fell(end_flag_second_n));
	cover property ($rose(cmd_rdata_oe));
	// release with no count after it falls back into the halt
	cover property (seq_write_block ##1 !seq_write_block ##1 seq_write_block);
endmodule // sbfc_core_sva

bind sbfc_core sbfc_core_sva sbfc_core_sva_inst (.*);

// [verif/sbfc_host.sv]
`timescale 1ns/1ps
module sbfc_host
	import sbfc_pkg::*;
(
	// clock
	input wire logic clk,
	// command pins
	output sbfc_pkg::sbfc_cmd_s cmd_pins,
	input wire logic [sbfc_pkg::DATA_W-1:0] cmd_rdata,
	input wire logic cmd_rdata_oe
);
	initial cmd_pins = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0};
	// long dwell because the pins pass a 3-flop sync
	task automatic xfer(input logic rw, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q,
		output logic oe);
		@(negedge clk);
		cmd_pins = '{1'b0, 1'b1, rw, a, d};
		repeat (8) @(negedge clk);
		q = cmd_rdata;
		oe = cmd_rdata_oe;
		cmd_pins.cmd_sel_n = 1'b1;
		cmd_pins.wdata = ~d;
		repeat (8) @(negedge clk);
	endtask
endmodule // sbfc_host

// [verif/sbfc_tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; $display("CHECK FAILED %s %h %h", n, e, a); end end
module sbfc_tb_top;
	import sbfc_pkg::*;
	logic clk = 0, rst_b = 0, cmd_rdata_oe, seq_write_block, end_flag_first_n, end_flag_second_n;
	sbfc_cmd_s cmd_pins;
	logic [15:0] cmd_rdata, q;
	logic oe_seen;
	sbfc_seq_ctl_s seq_ctl = 4'hf;
	logic [12:0] load_addr = 13'h0, seq_pointer;
	sbfc_bounds_s bounds = {13'h10, 13'h13, 13'h20, 13'h23};
	int err_count = 0, checks = 0;
	initial forever #4 clk = ~clk;
	sbfc_core sbfc_core_inst (.clk(clk), .rst_b(rst_b), .cmd_pins(cmd_pins), .cmd_rdata(cmd_rdata),
		.cmd_rdata_oe(cmd_rdata_oe), .seq_ctl(seq_ctl), .load_addr(load_addr), .bounds(bounds),
		.seq_pointer(seq_pointer), .seq_write_block(seq_write_block), .end_flag_first_n(end_flag_first_n),
		.end_flag_second_n(end_flag_second_n));
	sbfc_host sbfc_host_inst (.clk(clk), .cmd_pins(cmd_pins), .cmd_rdata(cmd_rdata),
		.cmd_rdata_oe(cmd_rdata_oe));
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		sbfc_host_inst.xfer(1'b0, a, d, q, oe_seen);
		`CHK("oe_on_write", 1'b0, oe_seen)
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		sbfc_host_inst.xfer(1'b1, a, 16'h0, q, oe_seen);
		`CHK("oe_on_read", 1'b1, oe_seen)
		`CHK("rdata", e, q)
	endtask
	task automatic ld(input logic [12:0] v);
		@(negedge clk);
		seq_ctl.pointer_load_n = 1'b0;
		load_addr = v;
		@(negedge clk);
		seq_ctl.pointer_load_n = 1'b1;
		@(negedge clk);
	endtask
	// two idle edges after the count; the flag pin is loaded on the same edge as its status bit
	task automatic cnt(input int n);
		seq_ctl.count_advance_enable_n = 1'b0;
		repeat (n) @(negedge clk);
		seq_ctl.count_advance_enable_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic cs(input logic [12:0] p, input logic [2:0] f);
		`CHK("ptr", p, seq_pointer)
		`CHK("blk_f1_f2", f, {seq_write_block, end_flag_first_n, end_flag_second_n})
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim;
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		cs(13'h0, 3'b011);
		rd(CMD_FLOW_CTRL, 16'hffe0);
		rd(CMD_FLAG_STAT, 16'h0);
		ld(13'h12);
		cnt(2);
		cs(13'h20, 3'b001);
		ld(13'h22);
		cnt(2);
		cs(13'h10, 3'b000);
		rd(CMD_FLAG_STAT, 16'h3);
		wr(CMD_FLAG_STAT, 16'hfffe);
		cs(13'h10, 3'b010);
		rd(CMD_FLAG_STAT, 16'h2);
		wr(CMD_FLAG_STAT, 16'h0);
		rd(CMD_FLAG_STAT, 16'h0);
		$display("test chain done");
		wr(CMD_FLOW_CTRL, 16'h0001);
		ld(13'h12);
		cnt(3);
		cs(13'h14, 3'b101);
		rd(CMD_FLOW_CTRL, 16'hfff1);
		seq_ctl.count_advance_enable_n = 1'b0;
		wr(CMD_FLOW_CTRL, 16'h0001);
		seq_ctl.count_advance_enable_n = 1'b1;
		`CHK("released", 1'b1, seq_pointer > 13'h14 && !seq_write_block)
		ld(13'h12);
		cnt(3);
		seq_ctl.jump_second_start_n = 1'b0;
		@(negedge clk);
		seq_ctl.jump_second_start_n = 1'b1;
		cs(13'h20, 3'b001);
		// no count at the end edge halts on the end itself
		ld(13'h13);
		@(negedge clk);
		cs(13'h13, 3'b101);
		// a release not followed by a count falls back into the halt
		wr(CMD_FLOW_CTRL, 16'h0001);
		cs(13'h13, 3'b101);
		seq_ctl.jump_first_start_n = 1'b0;
		@(negedge clk);
		seq_ctl.jump_first_start_n = 1'b1;
		cs(13'h10, 3'b001);
		$display("test stop done");
		for (int m = 2; m < 4; m++) begin
			wr(CMD_FLAG_STAT, 16'h0);
			wr(CMD_FLOW_CTRL, 16'(m));
			ld(13'h12);
			cnt(3);
			cs(13'h15, {1'b0, m[0], 1'b1});
			rd(CMD_FLAG_STAT, 16'h1);
		end
		wr(CMD_FLAG_STAT, 16'h0);
		wr(CMD_FLOW_CTRL, 16'h0);
		bounds.end_second = 13'h13;
		ld(13'h12);
		cnt(2);
		cs(13'h10, 3'b000);
		rd(CMD_FLAG_STAT, 16'h3);
		$display("test modes done");
		for (int c = 0; c < 8; c++)
			if (c < 4 || c > 5)
				rd(3'(c), 16'hffff);
		wr(CMD_FLOW_CTRL, 16'hffe0);
		rd(CMD_FLOW_CTRL, 16'hffe0);
		// mid-run reset with non-default modes and both status bits set
		wr(CMD_FLOW_CTRL, 16'h0006);
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		cs(13'h0, 3'b011);
		rd(CMD_FLOW_CTRL, 16'hffe0);
		rd(CMD_FLAG_STAT, 16'h0);
		$display("test command done");
		end_sim;
	end
endmodule // sbfc_tb_top
